/* File: core/pq_defs.svh */
// Constants for the power-quality event monitor
`ifndef PQ_DEFS_SVH
`define PQ_DEFS_SVH
`define PQ_NPH 3
`define PQ_RMS_W 32
`define PQ_LVL_W 16
`define PQ_RMS_TOP 31
`define PQ_RMS_LOW 16
`define PQ_ADC_W 12
`define PQ_ADC_FS 12'sd2047
`define PQ_ADC_FS_NEG -12'sd2048
`define PQ_MISS_PCT 10
`define PQ_MISS_LVL 12'd204
`define PQ_RATE_W 8
`define PQ_RATE_RST 8'hC7
`define PQ_SLOT_CLKS 8
`define PQ_NS_W 8
`define PQ_NS_RST 8'h64
`define PQ_SAG_CYCLE_COUNT_W 8
// Flag positions in the first event status word
`define PQ_ST_MISS 0
`define PQ_ST_VUNB 1
`define PQ_ST_IUNB 2
`define PQ_ST_W 3
`endif

/* File: core/pq_event_monitor.sv */
// Per-phase power-quality and tamper event monitor
`timescale 1ns/1ps
`include "pq_defs.svh"
module pq_event_monitor
	import pq_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] adc_frame_rate_setting,
	input wire logic [7:0] frames_per_line_cycle,
	input wire rms_pair_s [2:0] rms_in,
	input wire logic rms_valid,
	input wire adc_pair_s [2:0] adc_in,
	input wire logic adc_valid,
	input wire lvl_t overvoltage_threshold,
	input wire lvl_t overcurrent_threshold,
	input wire lvl_t sag_threshold,
	input wire logic [7:0] sag_cycle_count,
	input wire lvl_t voltage_unbalance_threshold,
	input wire lvl_t current_unbalance_threshold,
	input wire logic [2:0] overvoltage_monitor_enable,
	input wire logic [2:0] overcurrent_monitor_enable,
	input wire logic [11:0] irq_mask_n,
	input wire logic [11:0] flag_clear,
	output logic [2:0] overvoltage_flag,
	output logic [2:0] overcurrent_flag,
	output logic sag_flag_phase_a,
	output logic sag_flag_phase_b,
	output logic sag_flag_phase_c,
	output logic [2:0] missing_potential_phase_bit,
	output logic [2:0] event_status_first,
	output logic irq
);
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	logic frame_tick;
	logic cycle_tick;
	pq_frame_timer u_timer (
		.clock(clock),
		.rst(rst),
		.adc_frame_rate_setting(adc_frame_rate_setting),
		.frames_per_line_cycle(frames_per_line_cycle),
		.frame_tick(frame_tick),
		.cycle_tick(cycle_tick)
	);

	// Top 16 bits of a raw RMS word
	function automatic lvl_t rms_top(input rms_t w);
		return w[`PQ_RMS_TOP:`PQ_RMS_LOW];
	endfunction

	// Magnitude of a 14-bit signed sum
	function automatic logic [13:0] mag14(input logic signed [13:0] s);
		return s[13] ? 14'(-s) : s;
	endfunction

	// ------------------------------------------------------------
	// Over-level and sag checks
	// ------------------------------------------------------------
	logic [2:0] ov_hit;
	logic [2:0] oc_hit;
	logic [2:0] sag_hit;
	logic [2:0] sag_low;
	logic [2:0] sag_flags;
	logic [2:0] miss_hit;
	logic [7:0] sag_cnt_reg [3];

	genvar p;
	generate
		for (p = 0; p < 3; p++) begin : g_ph
			// Thresholds used as given, already meter units
			assign ov_hit[p] = rms_valid && overvoltage_monitor_enable[p]
				&& (rms_top(rms_in[p].v) > overvoltage_threshold);
			assign oc_hit[p] = rms_valid && overcurrent_monitor_enable[p]
				&& (rms_top(rms_in[p].i) > overcurrent_threshold);
			assign sag_low[p] = rms_top(rms_in[p].v) < sag_threshold;

			// Consecutive low line-cycle results
			always_ff @(posedge clock) begin
				if (rst) begin
					sag_cnt_reg[p] <= 8'h00;
				end else if (rms_valid) begin
					if (!sag_low[p]) begin
						sag_cnt_reg[p] <= 8'h00;
					end else if (sag_cnt_reg[p] != 8'hFF) begin
						sag_cnt_reg[p] <= sag_cnt_reg[p] + 8'h01;
					end
				end
			end
			assign sag_hit[p] = rms_valid && sag_low[p]
				&& ({1'b0, sag_cnt_reg[p]} + 9'h001
				>= {1'b0, sag_cycle_count});
		end
	endgenerate

	// ------------------------------------------------------------
	// Missing potential per line cycle
	// ------------------------------------------------------------
	logic [2:0] seen_pos_reg;
	logic [2:0] seen_neg_reg;
	logic [2:0] seen_big_reg;
	logic signed [11:0] adc_v [3];

	generate
		for (p = 0; p < 3; p++) begin : g_mp
			assign adc_v[p] = adc_in[p].v;
			always_ff @(posedge clock) begin
				if (rst || cycle_tick) begin
					seen_pos_reg[p] <= 1'b0;
					seen_neg_reg[p] <= 1'b0;
					seen_big_reg[p] <= 1'b0;
				end else if (adc_valid) begin
					if (adc_v[p] > 12'sd0)
						seen_pos_reg[p] <= 1'b1;
					if (adc_v[p] < 12'sd0)
						seen_neg_reg[p] <= 1'b1;
					if (mag14(14'(adc_v[p])) >= 14'(`PQ_MISS_LVL))
						seen_big_reg[p] <= 1'b1;
				end
			end
			// No crossing or no sample at 10% of full scale
			assign miss_hit[p] = cycle_tick && (!seen_big_reg[p]
				|| !(seen_pos_reg[p] && seen_neg_reg[p]));
		end
	endgenerate

	// ------------------------------------------------------------
	// Unbalance
	// ------------------------------------------------------------
	logic signed [13:0] v_sum;
	logic signed [13:0] i_sum;
	logic vunb_hit;
	logic iunb_hit;
	assign v_sum = 14'(adc_in[0].v) + 14'(adc_in[1].v) + 14'(adc_in[2].v);
	assign i_sum = 14'(adc_in[0].i) + 14'(adc_in[1].i) + 14'(adc_in[2].i);
	// Samples sit 4 bits below the RMS-top threshold scale;
	// 16 x |sum| above threshold is |sum| above threshold / 16
	assign vunb_hit = adc_valid && ({mag14(v_sum), 4'h0}
		> {2'b00, voltage_unbalance_threshold});
	assign iunb_hit = adc_valid && ({mag14(i_sum), 4'h0}
		> {2'b00, current_unbalance_threshold});

	// ------------------------------------------------------------
	// Sticky flags, set wins over clear
	// ------------------------------------------------------------
	// Clear bits: [2:0] ov, [5:3] oc, [8:6] sag, [11:9] status
	logic [11:0] set_vec;
	logic [11:0] flags_reg;
	assign set_vec = {vunb_hit && 1'b1, iunb_hit, |miss_hit, sag_hit,
		oc_hit, ov_hit};

	always_ff @(posedge clock) begin
		if (rst) begin
			flags_reg <= 12'h000;
		end else begin
			flags_reg <= (flags_reg & ~flag_clear) | set_vec;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			missing_potential_phase_bit <= 3'h0;
		end else begin
			// Summary clear drops every per-phase bit
			missing_potential_phase_bit <= (missing_potential_phase_bit
				& ~{3{flag_clear[9]}}) | miss_hit;
		end
	end

	logic [11:0] flags_now;
	assign flags_now = (flags_reg & ~flag_clear) | set_vec;
	assign sag_flags = flags_now[8:6];

	// Flag outputs mirror the sticky register's next value
	always_ff @(posedge clock) begin
		if (rst) begin
			overvoltage_flag <= 3'h0;
			overcurrent_flag <= 3'h0;
			sag_flag_phase_a <= 1'b0;
			sag_flag_phase_b <= 1'b0;
			sag_flag_phase_c <= 1'b0;
		end else begin
			overvoltage_flag <= flags_now[2:0];
			overcurrent_flag <= flags_now[5:3];
			sag_flag_phase_a <= sag_flags[0];
			sag_flag_phase_b <= sag_flags[1];
			sag_flag_phase_c <= sag_flags[2];
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			event_status_first <= 3'h0;
		end else begin
			event_status_first[`PQ_ST_MISS] <= flags_now[9];
			event_status_first[`PQ_ST_IUNB] <= flags_now[10];
			event_status_first[`PQ_ST_VUNB] <= flags_now[11];
		end
	end

	// ------------------------------------------------------------
	// Interrupt request
	// ------------------------------------------------------------
	// Mask bit set lets the flag interrupt
	always_ff @(posedge clock) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(flags_now & irq_mask_n);
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_ov_sets_flag: assert property (
		@(posedge clock) disable iff (rst)
		ov_hit[0] |=> overvoltage_flag[0])
		else $error("overvoltage not flagged");
	a_oc_sets_flag: assert property (
		@(posedge clock) disable iff (rst)
		oc_hit[1] |=> overcurrent_flag[1])
		else $error("overcurrent not flagged");
	a_ov_disabled_quiet: assert property (
		@(posedge clock) disable iff (rst)
		!overvoltage_monitor_enable[1] && !overvoltage_flag[1]
		|=> !overvoltage_flag[1])
		else $error("disabled check set flag");
	a_flag_sticky: assert property (
		@(posedge clock) disable iff (rst)
		overcurrent_flag[1] && !flag_clear[4] |=> overcurrent_flag[1])
		else $error("flag dropped without clear");
	a_sag_sticky: assert property (
		@(posedge clock) disable iff (rst)
		sag_flag_phase_c && !flag_clear[8] |=> sag_flag_phase_c)
		else $error("sag flag dropped without clear");
	a_clear_drops_flag: assert property (
		@(posedge clock) disable iff (rst)
		flag_clear[0] && !ov_hit[0] |=> !overvoltage_flag[0])
		else $error("host clear ignored");
	a_sag_count: assert property (
		@(posedge clock) disable iff (rst)
		rms_valid && sag_low[2] && sag_cnt_reg[2] == 8'h00
		&& sag_cycle_count > 8'h01 |-> !sag_hit[2])
		else $error("sag declared on first low result");
	a_sag_flag_set: assert property (
		@(posedge clock) disable iff (rst)
		sag_hit[2] |=> sag_flag_phase_c)
		else $error("sag C flag missed");
	a_miss_summary: assert property (
		@(posedge clock) disable iff (rst)
		|miss_hit |=> event_status_first[`PQ_ST_MISS])
		else $error("missing potential summary not set");
	a_miss_phase: assert property (
		@(posedge clock) disable iff (rst)
		miss_hit[0] |=> missing_potential_phase_bit[0])
		else $error("missing potential phase bit not set");
	a_vunb_flag: assert property (
		@(posedge clock) disable iff (rst)
		vunb_hit |=> event_status_first[`PQ_ST_VUNB])
		else $error("voltage unbalance not flagged");
	a_iunb_flag: assert property (
		@(posedge clock) disable iff (rst)
		iunb_hit |=> event_status_first[`PQ_ST_IUNB])
		else $error("current unbalance not flagged");
	a_irq_masked: assert property (
		@(posedge clock) disable iff (rst)
		irq |-> |($past(irq_mask_n) & {event_status_first[`PQ_ST_VUNB],
		event_status_first[`PQ_ST_IUNB], event_status_first[`PQ_ST_MISS],
		sag_flag_phase_c, sag_flag_phase_b, sag_flag_phase_a,
		overcurrent_flag, overvoltage_flag}))
		else $error("irq without unmasked flag");
	a_irq_ov: assert property (
		@(posedge clock) disable iff (rst)
		ov_hit[0] && irq_mask_n[0] |=> irq)
		else $error("enabled overvoltage gave no irq");

	c_ov_event: cover property (@(posedge clock) disable iff (rst)
		ov_hit[0] ##1 irq);
	c_sag_event: cover property (@(posedge clock) disable iff (rst)
		sag_hit[2]);
	c_miss_event: cover property (@(posedge clock) disable iff (rst)
		|miss_hit);
	c_clear: cover property (@(posedge clock) disable iff (rst)
		overvoltage_flag[0] && flag_clear[0] ##1 !overvoltage_flag[0]);
	c_unbalance: cover property (@(posedge clock) disable iff (rst)
		vunb_hit ##1 event_status_first[`PQ_ST_VUNB]);
endmodule

/* File: core/pq_frame_timer.sv */
// Scan frame and line-cycle timing generator
`timescale 1ns/1ps
`include "pq_defs.svh"
module pq_frame_timer
	import pq_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] adc_frame_rate_setting,
	input wire logic [7:0] frames_per_line_cycle,
	output logic frame_tick,
	output logic cycle_tick
);
	logic [2:0] sub_reg;
	logic [7:0] slot_reg;
	logic [7:0] frame_reg;
	logic slot_end;
	assign slot_end = (sub_reg == 3'(`PQ_SLOT_CLKS - 1));

	// Frame = (rate + 1) * 8 clocks
	always_ff @(posedge clock) begin
		if (rst) begin
			sub_reg <= 3'h0;
			slot_reg <= 8'h00;
			frame_tick <= 1'b0;
		end else begin
			sub_reg <= sub_reg + 3'h1;
			frame_tick <= 1'b0;
			if (slot_end) begin
				if (slot_reg >= adc_frame_rate_setting) begin
					slot_reg <= 8'h00;
					frame_tick <= 1'b1;
				end else begin
					slot_reg <= slot_reg + 8'h01;
				end
			end
		end
	end

	// Line cycle = frames_per_line_cycle frames
	always_ff @(posedge clock) begin
		if (rst) begin
			frame_reg <= 8'h00;
			cycle_tick <= 1'b0;
		end else begin
			cycle_tick <= 1'b0;
			if (frame_tick) begin
				if (frame_reg + 8'h01 >= frames_per_line_cycle) begin
					frame_reg <= 8'h00;
					cycle_tick <= 1'b1;
				end else begin
					frame_reg <= frame_reg + 8'h01;
				end
			end
		end
	end

	a_frame_gap: assert property (
		@(posedge clock) disable iff (rst)
		frame_tick |=> !frame_tick [*7])
		else $error("frame ticks closer than one slot");
	a_cycle_on_frame: assert property (
		@(posedge clock) disable iff (rst)
		cycle_tick |-> $past(frame_tick))
		else $error("cycle tick without frame tick");
endmodule

/* File: core/pq_pkg.sv */
// Types shared by the power-quality event monitor
package pq_pkg;
	typedef logic [31:0] rms_t;
	typedef logic [15:0] lvl_t;
	typedef struct packed {
		rms_t v;
		rms_t i;
	} rms_pair_s;
	typedef struct packed {
		logic signed [11:0] v;
		logic signed [11:0] i;
	} adc_pair_s;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_EVAL = 3'b010,
		ST_DONE = 3'b100
	} eval_state_e;
endpackage

/* File: dv/pq_host_model.sv */
// Host model that services flagged events
`timescale 1ns/1ps
module pq_host_model
	import pq_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic irq,
	input wire logic [11:0] service_mask,
	input wire logic [3:0] delay,
	output logic [11:0] flag_clear
);
	logic [3:0] wait_reg;
	// One clear pulse per request, after a set delay
	always_ff @(posedge clock) begin
		if (rst) begin
			flag_clear <= 12'h000;
			wait_reg <= 4'h0;
		end else if (flag_clear != 12'h000) begin
			flag_clear <= 12'h000;
			wait_reg <= 4'h0;
		end else if (irq && service_mask != 12'h000) begin
			if (wait_reg == delay) begin
				flag_clear <= service_mask;
			end else begin
				wait_reg <= wait_reg + 4'h1;
			end
		end else begin
			wait_reg <= 4'h0;
		end
	end
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the event monitor
`timescale 1ns/1ps
module testbench
	import pq_pkg::*;
;
	logic clock = 1'b0;
	logic rst = 1'b1;
	rms_pair_s [2:0] rms_in;
	adc_pair_s [2:0] adc_in;
	logic rms_valid = 1'b0;
	logic adc_valid = 1'b0;
	lvl_t ov_thr, oc_thr, sag_thr, vu_thr, iu_thr;
	logic [7:0] sag_cnt = 8'h03;
	logic [7:0] rate = 8'h00;
	logic [7:0] frames = 8'h02;
	logic [2:0] ov_en, oc_en;
	logic [11:0] irq_mask_n = 12'h000;
	logic [11:0] service_mask = 12'h000;
	logic [11:0] flag_clear;
	logic [2:0] ov_f, oc_f, miss_f, status;
	logic sag_a, sag_b, sag_c, irq, sgn = 1'b0;
	logic signed [11:0] va = 12'sd100;
	logic signed [11:0] ia = 12'sd0;
	int miscompares = 0;
	int n_tests = 0;

	always #4 clock = ~clock;

	// Phases B and C swing both ways and cancel; A is held small
	always @(negedge clock) begin
		sgn <= ~sgn;
		adc_valid <= 1'b1;
		adc_in[0] <= '{v: va, i: ia};
		adc_in[1] <= '{v: sgn ? 12'sd1000 : -12'sd1000, i: 12'sd0};
		adc_in[2] <= '{v: sgn ? -12'sd1000 : 12'sd1000, i: 12'sd0};
	end

	pq_event_monitor i_dut (.clock(clock), .rst(rst),
		.adc_frame_rate_setting(rate), .frames_per_line_cycle(frames),
		.rms_in(rms_in), .rms_valid(rms_valid), .adc_in(adc_in),
		.adc_valid(adc_valid), .overvoltage_threshold(ov_thr),
		.overcurrent_threshold(oc_thr), .sag_threshold(sag_thr),
		.sag_cycle_count(sag_cnt), .voltage_unbalance_threshold(vu_thr),
		.current_unbalance_threshold(iu_thr),
		.overvoltage_monitor_enable(ov_en),
		.overcurrent_monitor_enable(oc_en), .irq_mask_n(irq_mask_n),
		.flag_clear(flag_clear), .overvoltage_flag(ov_f),
		.overcurrent_flag(oc_f), .sag_flag_phase_a(sag_a),
		.sag_flag_phase_b(sag_b), .sag_flag_phase_c(sag_c),
		.missing_potential_phase_bit(miss_f),
		.event_status_first(status), .irq(irq));

	pq_host_model i_host (.clock(clock), .rst(rst), .irq(irq),
		.service_mask(service_mask), .delay(4'h4),
		.flag_clear(flag_clear));

	// ----------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------
	task automatic check(string name, logic [31:0] got, logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic cyc(int n);
		repeat (n) @(negedge clock);
	endtask

	task automatic set_rms(int ph, lvl_t vh, lvl_t vl, lvl_t ih, lvl_t il);
		rms_in[ph] = '{v: {vh, vl}, i: {ih, il}};
	endtask

	task automatic pulse_rms();
		rms_valid = 1'b1;
		cyc(1);
		rms_valid = 1'b0;
		cyc(1);
	endtask

	task automatic wait_irq_low();
		int k;
		for (k = 0; k < 50 && irq !== 1'b0; k++)
			cyc(1);
		if (k == 50) begin
			miscompares++;
			final_report();
		end
	endtask

	// ----------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------
	task automatic over_level();
		ov_thr = 16'h1000;
		oc_thr = 16'h2000;
		set_rms(0, 16'h1000, 16'hFFFF, 16'h3000, 16'h0000);
		set_rms(1, 16'hF000, 16'h0000, 16'h2001, 16'h0000);
		set_rms(2, 16'h0FFF, 16'hFFFF, 16'h2000, 16'hFFFF);
		pulse_rms();
		check("ov_edge", ov_f, 3'b000);
		set_rms(0, 16'h1001, 16'h0000, 16'h3000, 16'h0000);
		pulse_rms();
		check("ov_flag", ov_f, 3'b001);
		check("oc_flag", oc_f, 3'b010);
		set_rms(0, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
		set_rms(1, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
		pulse_rms();
		check("ov_sticky", {oc_f, ov_f}, 6'b010001);
		irq_mask_n = 12'h008;
		cyc(3);
		check("irq_masked", irq, 1'b0);
		irq_mask_n = 12'h009;
		cyc(2);
		check("irq_on", irq, 1'b1);
		service_mask = 12'h001;
		wait_irq_low();
		service_mask = 12'h000;
		check("ov_cleared", {oc_f, ov_f}, 6'b010000);
	endtask

	task automatic sag();
		ov_thr = 16'hFFFF;
		sag_thr = 16'h0200;
		set_rms(0, 16'h8000, 16'h0000, 16'h0000, 16'h0000);
		set_rms(1, 16'h8000, 16'h0000, 16'h0000, 16'h0000);
		set_rms(2, 16'h0100, 16'h0000, 16'h0000, 16'h0000);
		repeat (2) pulse_rms();
		set_rms(2, 16'h0300, 16'h0000, 16'h0000, 16'h0000);
		pulse_rms();
		set_rms(2, 16'h01FF, 16'hFFFF, 16'h0000, 16'h0000);
		repeat (2) pulse_rms();
		check("sag_early", sag_c, 1'b0);
		pulse_rms();
		check("sag_flags", {sag_a, sag_b, sag_c}, 3'b001);
	endtask

	task automatic tamper();
		irq_mask_n = 12'h200;
		service_mask = 12'h200;
		cyc(1);
		wait_irq_low();
		check("miss_cleared", {miss_f, status[0]}, 4'h0);
		service_mask = 12'h000;
		cyc(60);
		check("miss_phase", miss_f, 3'b001);
		check("miss_sum", status[0], 1'b1);
		vu_thr = 16'h0640;
		iu_thr = 16'h0320;
		ia = 12'sd50;
		cyc(5);
		check("unbal_edge", status[2:1], 2'b00);
		vu_thr = 16'h063F;
		cyc(4);
		check("v_unbal", status[2:1], 2'b01);
		iu_thr = 16'h031F;
		cyc(4);
		check("i_unbal", status[2:1], 2'b11);
	endtask

	// Cycles from one missing-potential rise to the next
	task automatic next_miss(output int n);
		n = 0;
		while (n < 200 && status[0] !== 1'b0) begin
			cyc(1);
			n++;
		end
		while (n < 200 && status[0] !== 1'b1) begin
			cyc(1);
			n++;
		end
		if (n == 200) begin
			miscompares++;
			final_report();
		end
	endtask

	// Line cycle = frames x (rate + 1) x 8 clocks
	task automatic frame_timing();
		int n;
		rate = 8'h01;
		frames = 8'h03;
		service_mask = 12'h200;
		next_miss(n);
		next_miss(n);
		check("line_cycle", n, 32'd48);
		service_mask = 12'h000;
	endtask

	initial begin
		for (int p = 0; p < 3; p++)
			set_rms(p, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
		{ov_thr, oc_thr, vu_thr, iu_thr} = {4{16'hFFFF}};
		sag_thr = 16'h0000;
		ov_en = 3'b101;
		oc_en = 3'b110;
		repeat (12) @(negedge clock);
		rst = 1'b0;
		cyc(1);
		check("irq_reset", irq, 1'b0);
		over_level();
		sag();
		tamper();
		frame_timing();
		final_report();
	end
endmodule
